// *** verilog/pscb_pkg.sv ***
// Package with register map, field positions and states of the power supply control block
package pscb_pkg;
  localparam logic [7:0] PSC_ADDR = 8'hF8;
  localparam logic [7:0] PM_STS2_ADDR = 8'h01;
  localparam logic [7:0] PM_CTL2_ADDR = 8'h03;
  localparam logic [7:0] SMI_ENABLE_TWO_ADDR = 8'h17;
  localparam logic [7:0] IRQ_STS_ADDR = 8'h20;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h21;

  localparam int PSC_STAY_OFF_BIT = 1;
  localparam int PSC_POWER_ON_BIT = 2;
  localparam int PSC_RST_SEEN_BIT = 3;
  localparam int PSC_WAKE_CTL_BIT = 4;
  localparam int PSC_SLP_TRAP_BIT = 5;
  localparam int PSC_SCI_BLOCK_BIT = 6;
  localparam logic [7:0] PSC_RW_MASK = 8'h76;

  localparam int STS2_WAKE_BIT = 0;
  localparam int STS2_SMI_BIT = 1;

  localparam int CTL2_SCI_ROUTE_ENABLE_BIT = 0;
  localparam int CTL2_SLP_TYP_LSB = 2;
  localparam int SLP_TYP_W = 3;
  localparam int CTL2_SLEEP_ENABLE_TRIGGER_BIT = 5;
  localparam logic [7:0] CTL2_RW_MASK = 8'h1D;

  localparam int SMI2_MASTER_BIT = 7;

  localparam int IRQ_RST_SEEN_BIT = 0;
  localparam int IRQ_SMI_BIT = 1;
  localparam int IRQ_SLEEP_BIT = 2;
  localparam int IRQ_WAKE_BIT = 3;
  localparam int IRQ_W = 4;

  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [0:0] {
    PSCB_RUN,
    PSCB_SLEEP
  } pscb_state_t;
endpackage : pscb_pkg

// *** verilog/pscb_smi_gen.sv ***
// SMI source merge, sticky pending flag and gated output pin
`timescale 1ns/1ps
module pscb_smi_gen (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sleepTrapHit,
  input wire logic sciEvent,
  input wire logic sciRouteEnable,
  input wire logic sciToSmiBlock,
  input wire logic smiMasterEnable,
  input wire logic smiClear,
  output logic smiPending,
  output logic smiEvent,
  output logic smiOutputPin_n
);
  typedef struct packed {
    logic pending;
    logic event_;
    logic pin_n;
  } pscb_smi_st_t;

  pscb_smi_st_t cur_ff;
  pscb_smi_st_t nxt_cur;
  logic sciSmi;
  logic raise;

  always_comb begin
    nxt_cur = cur_ff;
    // SCI events reach SMI only while SCI routing is off and not blocked
    sciSmi = sciEvent & ~sciRouteEnable & ~sciToSmiBlock;
    raise = sciSmi | sleepTrapHit;
    // A new source in the clearing cycle keeps the flag set
    if (raise) begin
      nxt_cur.pending = 1'b1;
    end else if (smiClear) begin
      nxt_cur.pending = 1'b0;
    end
    nxt_cur.event_ = raise;
    nxt_cur.pin_n = ~(nxt_cur.pending & smiMasterEnable);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cur_ff <= '{pending: 1'b0, event_: 1'b0, pin_n: 1'b1};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign smiPending = cur_ff.pending;
  assign smiEvent = cur_ff.event_;
  assign smiOutputPin_n = cur_ff.pin_n;
endmodule : pscb_smi_gen

// *** verilog/pscb_power_ctrl.sv ***
// Power supply control bits: standby return policy, wake flag, sleep trap and SCI to SMI routing
//
// Contract
// - With the power-on return option set and stay-off clear, a standby power-on reset drives supply_on_request_n low.
// - With neither return option set, a standby reset restores the power state held before.
// - A set button override flag suppresses the power-up on standby reset.
// - Hardware alone sets the standby reset seen flag on every standby power-on reset.
// - The standby reset seen flag clears only on a written one; a written zero leaves it.
// - Turning the supply on because of a standby reset raises no wake event.
// - The wake flag is set only while wake flag control is one, under its normal conditions.
// - With sleep trap select at zero, writing sleep enable enters the selected sleeping state.
// - With sleep trap select at one, writing sleep enable raises an SMI and does not sleep.
// - With SCI block and SCI routing both zero, each enabled SCI event raises an SMI.
// - With SCI block at one and SCI routing zero, enabled SCI events raise no SMI.
// - While SCI routing is one, PM1 and event block one events never raise an SMI here.
// - With the stay-off option set, a standby reset leaves the supply request inactive.
// - The SMI pin asserts only in the cycle after one in which the SMI master enable bit is one.
`timescale 1ns/1ps
module pscb_power_ctrl (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic standbyPorEvt,
  input wire logic buttonOverride,
  input wire logic powerOnReq,
  input wire logic powerOffReq,
  input wire logic wakeEvent,
  input wire logic [3:0] sciEvents,
  output logic supplyOnRequest_n,
  output logic sleepActive,
  output logic [2:0] sleepType,
  output logic pmeWake,
  output logic smiOutputPin_n,
  output logic irq
);
  typedef struct packed {
    logic [7:0] psc;
    logic wakeFlag;
    logic [7:0] ctl2;
    logic smiMaster;
    logic [pscb_pkg::IRQ_W-1:0] irqSts;
    logic [pscb_pkg::IRQ_W-1:0] irqMask;
    logic supplyOn;
    pscb_pkg::pscb_state_t state;
    logic [2:0] slpTyp;
    logic pme;
    logic irqOut;
    logic [7:0] rdData;
    logic supplyN;
    logic sleepOn;
  } pscb_st_t;

  pscb_st_t cur_ff;
  pscb_st_t nxt_cur;

  logic wrPsc;
  logic wrSts2;
  logic wrCtl2;
  logic wrSmi2;
  logic wrMask;
  logic rdIrq;
  logic slpWrite;
  logic sleepTrapHit;
  logic sleepEnter;
  logic sciEvent;
  logic smiClear;
  logic smiPending;
  logic smiEvent;
  logic [pscb_pkg::IRQ_W-1:0] irqSet;
  logic [7:0] wrKeep;

  pscb_smi_gen u_smi (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sleepTrapHit(sleepTrapHit),
    .sciEvent(sciEvent),
    .sciRouteEnable(cur_ff.ctl2[pscb_pkg::CTL2_SCI_ROUTE_ENABLE_BIT]),
    .sciToSmiBlock(cur_ff.psc[pscb_pkg::PSC_SCI_BLOCK_BIT]),
    .smiMasterEnable(cur_ff.smiMaster),
    .smiClear(smiClear),
    .smiPending(smiPending),
    .smiEvent(smiEvent),
    .smiOutputPin_n(smiOutputPin_n)
  );

  always_comb begin
    nxt_cur = cur_ff;
    wrPsc = regWr && (regAddr == pscb_pkg::PSC_ADDR);
    wrSts2 = regWr && (regAddr == pscb_pkg::PM_STS2_ADDR);
    wrCtl2 = regWr && (regAddr == pscb_pkg::PM_CTL2_ADDR);
    wrSmi2 = regWr && (regAddr == pscb_pkg::SMI_ENABLE_TWO_ADDR);
    wrMask = regWr && (regAddr == pscb_pkg::IRQ_MASK_ADDR);
    rdIrq = regRd && (regAddr == pscb_pkg::IRQ_STS_ADDR);
    slpWrite = wrCtl2 && regWrData[pscb_pkg::CTL2_SLEEP_ENABLE_TRIGGER_BIT];
    sleepTrapHit = slpWrite && cur_ff.psc[pscb_pkg::PSC_SLP_TRAP_BIT];
    sleepEnter = slpWrite && !cur_ff.psc[pscb_pkg::PSC_SLP_TRAP_BIT] &&
                 (cur_ff.state == pscb_pkg::PSCB_RUN);
    sciEvent = |sciEvents;
    smiClear = wrSts2 && regWrData[pscb_pkg::STS2_SMI_BIT];
    irqSet = '0;

    // Option bits clear on reset_n like every other register; there is no separate battery reset
    if (wrPsc) begin
      wrKeep = cur_ff.psc & ~pscb_pkg::PSC_RW_MASK;
      nxt_cur.psc = wrKeep | (regWrData & pscb_pkg::PSC_RW_MASK);
      if (regWrData[pscb_pkg::PSC_RST_SEEN_BIT]) begin
        nxt_cur.psc[pscb_pkg::PSC_RST_SEEN_BIT] = 1'b0;
      end
    end else begin
      wrKeep = cur_ff.psc;
    end
    if (wrCtl2) begin
      nxt_cur.ctl2 = regWrData & pscb_pkg::CTL2_RW_MASK;
    end
    if (wrSmi2) begin
      nxt_cur.smiMaster = regWrData[pscb_pkg::SMI2_MASTER_BIT];
    end
    if (wrMask) begin
      nxt_cur.irqMask = regWrData[pscb_pkg::IRQ_W-1:0];
    end
    if (wrSts2 && regWrData[pscb_pkg::STS2_WAKE_BIT]) begin
      nxt_cur.wakeFlag = 1'b0;
    end

    // Supply request: ordinary on/off requests first, standby reset decides last
    if (powerOnReq) begin
      nxt_cur.supplyOn = 1'b1;
    end else if (powerOffReq) begin
      nxt_cur.supplyOn = 1'b0;
    end
    if (standbyPorEvt) begin
      nxt_cur.psc[pscb_pkg::PSC_RST_SEEN_BIT] = 1'b1;
      irqSet[pscb_pkg::IRQ_RST_SEEN_BIT] = 1'b1;
      if (buttonOverride) begin
        nxt_cur.supplyOn = 1'b0;
      end else if (cur_ff.psc[pscb_pkg::PSC_STAY_OFF_BIT]) begin
        nxt_cur.supplyOn = 1'b0;
      end else if (cur_ff.psc[pscb_pkg::PSC_POWER_ON_BIT]) begin
        nxt_cur.supplyOn = 1'b1;
      end else begin
        nxt_cur.supplyOn = cur_ff.supplyOn;
      end
    end

    // Wake event pulse comes only from real wake sources, never from the standby reset path
    nxt_cur.pme = 1'b0;
    case (cur_ff.state)
      pscb_pkg::PSCB_RUN: begin
        if (sleepEnter) begin
          nxt_cur.state = pscb_pkg::PSCB_SLEEP;
          nxt_cur.slpTyp = regWrData[pscb_pkg::CTL2_SLP_TYP_LSB +: pscb_pkg::SLP_TYP_W];
          irqSet[pscb_pkg::IRQ_SLEEP_BIT] = 1'b1;
        end
      end
      pscb_pkg::PSCB_SLEEP: begin
        if (wakeEvent) begin
          nxt_cur.state = pscb_pkg::PSCB_RUN;
          nxt_cur.pme = 1'b1;
          irqSet[pscb_pkg::IRQ_WAKE_BIT] = 1'b1;
          if (cur_ff.psc[pscb_pkg::PSC_WAKE_CTL_BIT]) begin
            nxt_cur.wakeFlag = 1'b1;
          end
        end
      end
      default: begin
        nxt_cur.state = pscb_pkg::PSCB_RUN;
      end
    endcase
    irqSet[pscb_pkg::IRQ_SMI_BIT] = smiEvent;

    // Read clears the status, but an event landing in the same cycle survives
    if (rdIrq) begin
      nxt_cur.irqSts = irqSet;
    end else begin
      nxt_cur.irqSts = cur_ff.irqSts | irqSet;
    end
    nxt_cur.irqOut = |(nxt_cur.irqSts & nxt_cur.irqMask);
    // Pin levels are kept in their own flops so no gate sits behind the outputs
    nxt_cur.supplyN = ~nxt_cur.supplyOn;
    nxt_cur.sleepOn = (nxt_cur.state == pscb_pkg::PSCB_SLEEP);

    nxt_cur.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        pscb_pkg::PSC_ADDR: nxt_cur.rdData = cur_ff.psc;
        pscb_pkg::PM_STS2_ADDR: nxt_cur.rdData = {6'h00, smiPending, cur_ff.wakeFlag};
        pscb_pkg::PM_CTL2_ADDR: nxt_cur.rdData = cur_ff.ctl2;
        pscb_pkg::SMI_ENABLE_TWO_ADDR: nxt_cur.rdData = {cur_ff.smiMaster, 7'h00};
        pscb_pkg::IRQ_STS_ADDR: nxt_cur.rdData = {4'h0, cur_ff.irqSts};
        pscb_pkg::IRQ_MASK_ADDR: nxt_cur.rdData = {4'h0, cur_ff.irqMask};
        default: nxt_cur.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cur_ff <= '{psc: pscb_pkg::REG_RESET, wakeFlag: 1'b0, ctl2: pscb_pkg::REG_RESET,
                  smiMaster: 1'b0, irqSts: '0, irqMask: '0, supplyOn: 1'b0,
                  state: pscb_pkg::PSCB_RUN, slpTyp: 3'h0, pme: 1'b0, irqOut: 1'b0,
                  rdData: 8'h00, supplyN: 1'b1, sleepOn: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign regRdData = cur_ff.rdData;
  assign supplyOnRequest_n = cur_ff.supplyN;
  assign sleepActive = cur_ff.sleepOn;
  assign sleepType = cur_ff.slpTyp;
  assign pmeWake = cur_ff.pme;
  assign irq = cur_ff.irqOut;
endmodule : pscb_power_ctrl

// *** test/pscb_power_ctrl_checker.sv ***
// Port checker of the power supply control block
`timescale 1ns/1ps
module pscb_power_ctrl_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic standbyPorEvt,
  input wire logic buttonOverride,
  input wire logic wakeEvent,
  input wire logic [3:0] sciEvents,
  input wire logic supplyOnRequest_n,
  input wire logic sleepActive,
  input wire logic [2:0] sleepType,
  input wire logic pmeWake,
  input wire logic smiOutputPin_n
);
  typedef struct packed {logic [7:0] psc; logic route; logic master;} pscb_shadow_t;
  pscb_shadow_t sh_ff, nxt_sh;
  logic ctlWr;
  logic sciAny;
  assign ctlWr = regWr && regAddr == pscb_pkg::PM_CTL2_ADDR && regWrData[5];
  assign sciAny = |sciEvents;
  // Shadow of control bits seen on the bus
  always_comb begin
    nxt_sh = sh_ff;
    if (regWr && regAddr == pscb_pkg::PSC_ADDR) nxt_sh.psc = regWrData;
    if (regWr && regAddr == pscb_pkg::PM_CTL2_ADDR) nxt_sh.route = regWrData[0];
    if (regWr && regAddr == pscb_pkg::SMI_ENABLE_TWO_ADDR) nxt_sh.master = regWrData[7];
    if (!reset_n) nxt_sh = '0;
  end
  always_ff @(posedge ref_clk) begin
    sh_ff <= nxt_sh;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  por_on_a: assert property (standbyPorEvt && sh_ff.psc[2] && !buttonOverride |=> !supplyOnRequest_n)
    else $error("supply not requested");
  por_off_a: assert property (standbyPorEvt && sh_ff.psc[1] |=> supplyOnRequest_n)
    else $error("supply requested with stay off");
  override_a: assert property (standbyPorEvt && buttonOverride |=> supplyOnRequest_n)
    else $error("override ignored");
  no_wake_a: assert property (standbyPorEvt && !sleepActive |=> !pmeWake)
    else $error("wake on standby reset");
  smi_gate_a: assert property (!smiOutputPin_n |-> sh_ff.master || $past(sh_ff.master))
    else $error("smi pin without master enable");
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");
  sleep_enter_a: assert property (ctlWr && !sleepActive && !sh_ff.psc[5]
    |=> sleepActive && sleepType == $past(regWrData[4:2]))
    else $error("sleep not entered");
  trap_a: assert property (ctlWr && !sleepActive && sh_ff.psc[5] && sh_ff.master
    |=> !sleepActive && !smiOutputPin_n)
    else $error("sleep trap failed");
  sci_smi_a: assert property (sciAny && !sh_ff.route && !sh_ff.psc[6] && sh_ff.master |=> !smiOutputPin_n)
    else $error("sci gave no smi");
  sci_block_a: assert property (sciAny && (sh_ff.route || sh_ff.psc[6]) && smiOutputPin_n && !regWr
    |=> smiOutputPin_n)
    else $error("blocked sci gave smi");
  cover property (ctlWr && !sleepActive && !sh_ff.psc[5]);
  cover property (standbyPorEvt && buttonOverride);
  cover property (sleepActive && wakeEvent);
endmodule : pscb_power_ctrl_checker

// *** test/pscb_power_ctrl_tb_top.sv ***
// Self-checking bench of the power supply control block
`timescale 1ns/1ps
module pscb_power_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic standbyPorEvt = 1'b0;
  logic buttonOverride = 1'b0;
  logic powerOnReq = 1'b0;
  logic powerOffReq = 1'b0;
  logic wakeEvent = 1'b0;
  logic [3:0] sciEvents = 4'h0;
  logic [7:0] regRdData;
  logic [2:0] sleepType;
  logic supplyOnRequest_n, sleepActive, pmeWake, smiOutputPin_n, irq;
  int n_fail = 0;
  int samples_checked = 0;
  pscb_power_ctrl DUT (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .standbyPorEvt(standbyPorEvt),
    .buttonOverride(buttonOverride), .powerOnReq(powerOnReq), .powerOffReq(powerOffReq),
    .wakeEvent(wakeEvent), .sciEvents(sciEvents), .supplyOnRequest_n(supplyOnRequest_n),
    .sleepActive(sleepActive), .sleepType(sleepType), .pmeWake(pmeWake),
    .smiOutputPin_n(smiOutputPin_n), .irq(irq));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData === e, "read data");
  endtask : rd
  // One-cycle event pulse: por, power on, power off, wake, sci
  task automatic ev(input logic [4:0] m);
    @(posedge ref_clk);
    {standbyPorEvt, powerOnReq, powerOffReq, wakeEvent, sciEvents[0]} <= m;
    @(posedge ref_clk);
    {standbyPorEvt, powerOnReq, powerOffReq, wakeEvent, sciEvents[0]} <= 5'h00;
    #1;
  endtask : ev
  task automatic t_regs;
    rd(pscb_pkg::PSC_ADDR, 8'h00);
    wr(pscb_pkg::PSC_ADDR, 8'hF4);
    rd(pscb_pkg::PSC_ADDR, 8'h74);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
  endtask : t_regs
  task automatic t_por;
    wr(pscb_pkg::IRQ_MASK_ADDR, 8'h01);
    wr(pscb_pkg::PSC_ADDR, 8'h04);
    ev(5'h10);
    chk({supplyOnRequest_n, irq, pmeWake} === 3'b010, "por on");
    rd(pscb_pkg::PSC_ADDR, 8'h0C);
    wr(pscb_pkg::PSC_ADDR, 8'h04);
    rd(pscb_pkg::PSC_ADDR, 8'h0C);
    wr(pscb_pkg::PSC_ADDR, 8'h0C);
    rd(pscb_pkg::PSC_ADDR, 8'h04);
    rd(pscb_pkg::IRQ_STS_ADDR, 8'h01);
    chk(irq === 1'b0, "irq clear");
  endtask : t_por
  task automatic t_ret;
    wr(pscb_pkg::PSC_ADDR, 8'h02);
    ev(5'h10);
    chk(supplyOnRequest_n === 1'b1, "stay off");
    wr(pscb_pkg::PSC_ADDR, 8'h04);
    @(posedge ref_clk);
    buttonOverride <= 1'b1;
    ev(5'h10);
    chk(supplyOnRequest_n === 1'b1, "override");
    @(posedge ref_clk);
    buttonOverride <= 1'b0;
    ev(5'h08);
    wr(pscb_pkg::PSC_ADDR, 8'h00);
    ev(5'h10);
    chk(supplyOnRequest_n === 1'b0, "restore on");
    ev(5'h04);
    ev(5'h10);
    chk(supplyOnRequest_n === 1'b1, "restore off");
  endtask : t_ret
  task automatic t_sleep;
    wr(pscb_pkg::SMI_ENABLE_TWO_ADDR, 8'h80);
    wr(pscb_pkg::PM_CTL2_ADDR, 8'h34);
    chk({sleepActive, sleepType} === 4'hD, "sleep entry");
    ev(5'h02);
    chk({sleepActive, pmeWake} === 2'b01, "wake");
    rd(pscb_pkg::PM_STS2_ADDR, 8'h00);
    wr(pscb_pkg::PSC_ADDR, 8'h10);
    wr(pscb_pkg::PM_CTL2_ADDR, 8'h24);
    ev(5'h02);
    rd(pscb_pkg::PM_STS2_ADDR, 8'h01);
    wr(pscb_pkg::PSC_ADDR, 8'h20);
    wr(pscb_pkg::PM_CTL2_ADDR, 8'h24);
    chk({sleepActive, smiOutputPin_n} === 2'b00, "trap");
    rd(pscb_pkg::PM_STS2_ADDR, 8'h03);
    wr(pscb_pkg::PM_STS2_ADDR, 8'h03);
  endtask : t_sleep
  task automatic t_sci;
    wr(pscb_pkg::PSC_ADDR, 8'h00);
    ev(5'h01);
    chk(smiOutputPin_n === 1'b0, "sci smi");
    wr(pscb_pkg::SMI_ENABLE_TWO_ADDR, 8'h00);
    @(posedge ref_clk);
    #1;
    chk(smiOutputPin_n === 1'b1, "master off");
    wr(pscb_pkg::PM_STS2_ADDR, 8'h02);
    wr(pscb_pkg::SMI_ENABLE_TWO_ADDR, 8'h80);
    wr(pscb_pkg::PSC_ADDR, 8'h40);
    ev(5'h01);
    chk(smiOutputPin_n === 1'b1, "sci blocked");
    wr(pscb_pkg::PSC_ADDR, 8'h00);
    wr(pscb_pkg::PM_CTL2_ADDR, 8'h01);
    ev(5'h01);
    chk(smiOutputPin_n === 1'b1, "sci routed");
  endtask : t_sci
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs;
    t_por;
    t_ret;
    t_sleep;
    t_sci;
    complete_run;
  end
  // The sequence needs some 100 cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_fail++;
    complete_run;
  end
endmodule : pscb_power_ctrl_tb_top
bind pscb_power_ctrl pscb_power_ctrl_checker chk_i (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .standbyPorEvt(standbyPorEvt),
  .buttonOverride(buttonOverride), .wakeEvent(wakeEvent), .sciEvents(sciEvents),
  .supplyOnRequest_n(supplyOnRequest_n), .sleepActive(sleepActive), .sleepType(sleepType), .pmeWake(pmeWake),
  .smiOutputPin_n(smiOutputPin_n));
